// ---- fsw_pkg.sv ----
// Package with constants and types for the status-word logic
package fsw_pkg;

  // ----------------------------------------------------------------
  // Register map (two select lines, status read at code zero)
  // ----------------------------------------------------------------
  localparam logic [1:0] FSW_ADDR_STATUS = 2'h0;
  localparam logic [1:0] FSW_ADDR_DATA = 2'h3;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int FSW_BIT_NOT_READY = 7;
  localparam int FSW_BIT_PROTECT = 6;
  localparam int FSW_BIT_REC_TYPE = 5;
  localparam int FSW_BIT_NOT_FOUND = 4;
  localparam int FSW_BIT_CRC = 3;
  localparam int FSW_BIT_TRACK_LOST = 2;
  localparam int FSW_BIT_INDEX_DRQ = 1;
  localparam int FSW_BIT_BUSY = 0;

  // Word value after reset, before the not-ready term is merged in
  localparam logic [7:0] FSW_STATUS_RESET = 8'h20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FSW_CLK_MHZ = 50;
  localparam int FSW_DRQ_RELEASE_NS = 150;
  localparam int FSW_IRQ_RELEASE_NS = 500;
  localparam int FSW_STEP_MFM_NS = 6000;
  localparam int FSW_STEP_FM_NS = 12000;
  // Longest times round down, least times round up
  localparam int FSW_DRQ_RELEASE_CYC = FSW_DRQ_RELEASE_NS * FSW_CLK_MHZ / 1000;
  localparam int FSW_IRQ_RELEASE_CYC = FSW_IRQ_RELEASE_NS * FSW_CLK_MHZ / 1000;
  localparam int FSW_STEP_MFM_CYC = (FSW_STEP_MFM_NS * FSW_CLK_MHZ + 999) / 1000;
  localparam int FSW_STEP_FM_CYC = (FSW_STEP_FM_NS * FSW_CLK_MHZ + 999) / 1000;
  localparam int FSW_STEP_CNT_W = 11;

  // ----------------------------------------------------------------
  // Command classes, as decoded by the command logic outside
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FSW_CMD_POSITION,
    FSW_CMD_READ_DATA,
    FSW_CMD_WRITE_DATA,
    FSW_CMD_READ_ADDRESS,
    FSW_CMD_TRACK_RW,
    FSW_CMD_FORMAT,
    FSW_CMD_MISC
  } fsw_cmd_t;

endpackage

// ---- fsw_status_word.sv ----
// Status-word register, request release and step pulse shaping
`timescale 1ns/1ps

module fsw_status_word
  import fsw_pkg::*;
#(
  parameter int STEP_MFM_CYC = FSW_STEP_MFM_CYC,
  parameter int STEP_FM_CYC = FSW_STEP_FM_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic master_reset_n,
  input wire logic drive_ready_in,
  input wire logic write_protect_in,
  input wire logic outer_track_in,
  input wire logic index_pulse_in,
  input wire logic [1:0] reg_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cmd_start,
  input wire fsw_cmd_t cmd_class,
  input wire logic cmd_done,
  input wire logic force_irq,
  input wire logic extended_mode,
  input wire logic mfm_mode,
  input wire logic verify_fail,
  input wire logic crc_error,
  input wire logic mark_missing,
  input wire logic deleted_mark,
  input wire logic record_not_found,
  input wire logic lost_data,
  input wire logic data_request_set,
  input wire logic irq_set,
  input wire logic step_request,
  output logic [7:0] status_word,
  output logic data_request_out,
  output logic irq_out,
  output logic step_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, a change counts once 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] rdy_sync_reg, wp_sync_reg, tr_sync_reg, ip_sync_reg, mr_sync_reg;
  logic [2:0] re_sync_reg, we_sync_reg;
  logic rdy_reg, wp_reg, tr_reg, ip_reg, mr_reg, re_reg, we_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdy_sync_reg <= 3'h0;
      wp_sync_reg <= 3'h7;
      tr_sync_reg <= 3'h7;
      ip_sync_reg <= 3'h7;
      mr_sync_reg <= 3'h0;
      re_sync_reg <= 3'h7;
      we_sync_reg <= 3'h7;
    end else begin
      rdy_sync_reg <= {rdy_sync_reg[1:0], drive_ready_in};
      wp_sync_reg <= {wp_sync_reg[1:0], write_protect_in};
      tr_sync_reg <= {tr_sync_reg[1:0], outer_track_in};
      ip_sync_reg <= {ip_sync_reg[1:0], index_pulse_in};
      mr_sync_reg <= {mr_sync_reg[1:0], master_reset_n};
      re_sync_reg <= {re_sync_reg[1:0], read_strobe_n};
      we_sync_reg <= {we_sync_reg[1:0], write_strobe_n};
    end
  end

  // Filtered levels: held until stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdy_reg <= 1'b0;
      wp_reg <= 1'b1;
      tr_reg <= 1'b1;
      ip_reg <= 1'b1;
      mr_reg <= 1'b0;
      re_reg <= 1'b1;
      we_reg <= 1'b1;
    end else begin
      if (rdy_sync_reg[1] == rdy_sync_reg[2]) rdy_reg <= rdy_sync_reg[2];
      if (wp_sync_reg[1] == wp_sync_reg[2]) wp_reg <= wp_sync_reg[2];
      if (tr_sync_reg[1] == tr_sync_reg[2]) tr_reg <= tr_sync_reg[2];
      if (ip_sync_reg[1] == ip_sync_reg[2]) ip_reg <= ip_sync_reg[2];
      if (mr_sync_reg[1] == mr_sync_reg[2]) mr_reg <= mr_sync_reg[2];
      if (re_sync_reg[1] == re_sync_reg[2]) re_reg <= re_sync_reg[2];
      if (we_sync_reg[1] == we_sync_reg[2]) we_reg <= we_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Register select: synced like the strobes, so both line up
  // ----------------------------------------------------------------
  logic [1:0] sel_s0_reg, sel_s1_reg, sel_s2_reg, sel_reg;

  // Three stages; only the second stage reads the first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_s0_reg <= 2'h0;
      sel_s1_reg <= 2'h0;
      sel_s2_reg <= 2'h0;
    end else begin
      sel_s0_reg <= reg_select;
      sel_s1_reg <= sel_s0_reg;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // Select taken once stages two and three agree; a select that moves
  // during a strobe is a host fault and is not guarded against
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_reg <= 2'h0;
    end else if (sel_s1_reg == sel_s2_reg) begin
      sel_reg <= sel_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  logic re_prev_reg, we_prev_reg;
  wire re_fall = re_prev_reg & ~re_reg;
  wire we_fall = we_prev_reg & ~we_reg;
  wire status_read = re_fall & (sel_reg == FSW_ADDR_STATUS);
  // Only the data register services a data request
  wire data_access = (re_fall | we_fall) & (sel_reg == FSW_ADDR_DATA);
  wire in_reset = rst | ~mr_reg;
  wire not_ready = ~rdy_reg | ~mr_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      re_prev_reg <= 1'b1;
      we_prev_reg <= 1'b1;
    end else begin
      re_prev_reg <= re_reg;
      we_prev_reg <= we_reg;
    end
  end

  // ----------------------------------------------------------------
  // Command state and sticky error bits
  // ----------------------------------------------------------------
  logic busy_reg;
  fsw_cmd_t layout_reg;
  logic idle_force_reg;
  logic verify_reg, crc_reg, mark_reg, deleted_reg, rnf_reg, lost_reg;

  wire any_start = cmd_start;

  // Preset at start, set as events arrive, frozen once done except for the verify and CRC clear of an idle force interrupt
  always_ff @(posedge sys_clk) begin
    if (in_reset) begin
      busy_reg <= 1'b0;
      layout_reg <= FSW_CMD_POSITION;
      idle_force_reg <= 1'b0;
      verify_reg <= 1'b0;
      crc_reg <= 1'b0;
      mark_reg <= 1'b0;
      deleted_reg <= 1'b0;
      rnf_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else if (any_start) begin
      busy_reg <= 1'b1;
      layout_reg <= cmd_class;
      idle_force_reg <= 1'b0;
      verify_reg <= 1'b0;
      crc_reg <= 1'b0;
      mark_reg <= 1'b0;
      deleted_reg <= 1'b0;
      rnf_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else if (force_irq && !busy_reg) begin
      // Idle force interrupt: positioning layout, verify and CRC bits cleared
      layout_reg <= FSW_CMD_POSITION;
      idle_force_reg <= 1'b1;
      verify_reg <= 1'b0;
      crc_reg <= 1'b0;
    end else if (busy_reg) begin
      // Force interrupt while running only ends it; layout stays
      if (cmd_done || force_irq) busy_reg <= 1'b0;
      verify_reg <= verify_reg | verify_fail;
      crc_reg <= crc_reg | crc_error;
      mark_reg <= mark_reg | mark_missing;
      deleted_reg <= deleted_reg | deleted_mark;
      rnf_reg <= rnf_reg | record_not_found;
      lost_reg <= lost_reg | lost_data;
    end
  end

  // ----------------------------------------------------------------
  // Status word assembly per layout
  // ----------------------------------------------------------------
  logic [7:0] word_next;

  always_comb begin
    word_next = 8'h00;
    unique case (layout_reg)
      FSW_CMD_POSITION: begin
        word_next[FSW_BIT_PROTECT] = ~wp_reg;
        word_next[FSW_BIT_REC_TYPE] = ~idle_force_reg;
        word_next[FSW_BIT_NOT_FOUND] = verify_reg & ~idle_force_reg;
        word_next[FSW_BIT_CRC] = crc_reg & ~idle_force_reg;
        word_next[FSW_BIT_TRACK_LOST] = ~tr_reg;
        word_next[FSW_BIT_INDEX_DRQ] = ~ip_reg;
      end
      FSW_CMD_READ_DATA: begin
        word_next[FSW_BIT_PROTECT] = mark_reg & extended_mode;
        word_next[FSW_BIT_REC_TYPE] = deleted_reg;
        word_next[FSW_BIT_NOT_FOUND] = rnf_reg;
        word_next[FSW_BIT_CRC] = crc_reg;
      end
      FSW_CMD_WRITE_DATA, FSW_CMD_READ_ADDRESS: begin
        word_next[FSW_BIT_NOT_FOUND] = rnf_reg;
        word_next[FSW_BIT_CRC] = crc_reg;
      end
      FSW_CMD_TRACK_RW, FSW_CMD_FORMAT: begin
        word_next[FSW_BIT_PROTECT] = ~wp_reg;
        // Format reports an illegal length through the CRC position
        word_next[FSW_BIT_CRC] = crc_reg & (layout_reg == FSW_CMD_FORMAT);
      end
      FSW_CMD_MISC: begin
        word_next = 8'h00;
      end
      default: begin
        word_next = 8'h00;
      end
    endcase
    if (layout_reg != FSW_CMD_POSITION && layout_reg != FSW_CMD_MISC) begin
      word_next[FSW_BIT_TRACK_LOST] = lost_reg;
      word_next[FSW_BIT_INDEX_DRQ] = data_request_out;
    end
    word_next[FSW_BIT_NOT_READY] = not_ready;
    word_next[FSW_BIT_BUSY] = busy_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_word <= FSW_STATUS_RESET | 8'h80;
    end else begin
      status_word <= word_next;
    end
  end

  // ----------------------------------------------------------------
  // Data request and interrupt release
  // ----------------------------------------------------------------
  // Pin to release takes five cycles (100 ns at 50 MHz), inside both limits.
  // Set wins over clear so a request that coincides with service is kept.
  always_ff @(posedge sys_clk) begin
    if (in_reset) begin
      data_request_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (data_request_set) data_request_out <= 1'b1;
      else if (data_access) data_request_out <= 1'b0;
      if (irq_set || force_irq) irq_out <= 1'b1;
      else if (status_read) irq_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Step pulse stretcher
  // ----------------------------------------------------------------
  logic [FSW_STEP_CNT_W-1:0] step_cnt_reg;
  wire [FSW_STEP_CNT_W-1:0] step_len = mfm_mode ? FSW_STEP_CNT_W'(STEP_MFM_CYC)
                                                : FSW_STEP_CNT_W'(STEP_FM_CYC);

  // Pulse stands for the full minimum; requests during a pulse are dropped
  always_ff @(posedge sys_clk) begin
    if (in_reset) begin
      step_cnt_reg <= '0;
      step_out <= 1'b0;
    end else if (step_cnt_reg != '0) begin
      step_cnt_reg <= step_cnt_reg - 1'b1;
      step_out <= (step_cnt_reg != FSW_STEP_CNT_W'(1));
    end else if (step_request) begin
      step_cnt_reg <= step_len;
      step_out <= 1'b1;
    end
  end

endmodule

// ---- fsw_status_word_monitor.sv ----
// Port checker for the status-word block
`timescale 1ns/1ps
module fsw_status_word_mon
  import fsw_pkg::*;
#(
  parameter int STEP_MFM_CYC = FSW_STEP_MFM_CYC,
  parameter int STEP_FM_CYC = FSW_STEP_FM_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic master_reset_n,
  input wire logic drive_ready_in,
  input wire logic [1:0] reg_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cmd_start,
  input wire fsw_cmd_t cmd_class,
  input wire logic cmd_done,
  input wire logic crc_error,
  input wire logic mfm_mode,
  input wire logic [7:0] status_word,
  input wire logic data_request_out,
  input wire logic irq_out,
  input wire logic step_out
);
  // 150 ns and 500 ns limits in whole cycles, rounded down
  localparam int DRQ_MAX = 7;
  localparam int IRQ_MAX = 25;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  fsw_cmd_t cls_reg;
  logic [11:0] hi_reg;
  // Running class and step high time; width counter too wide to wrap in any legal pulse
  always_ff @(posedge sys_clk) begin
    if (cmd_start) cls_reg <= cmd_class;
    hi_reg <= step_out ? hi_reg + 12'h1 : 12'h0;
  end
  a_busy_on_start: assert property (cmd_start |-> ##2 status_word[FSW_BIT_BUSY])
    else $error("busy bit missing after start");
  a_busy_off_done: assert property ((cmd_done && !cmd_start ##1 !cmd_start)
    |-> ##1 !status_word[FSW_BIT_BUSY])
    else $error("busy bit kept after done");
  a_not_ready_bit: assert property ((!drive_ready_in || !master_reset_n) [*8] |-> status_word[7])
    else $error("not-ready bit low");
  a_reset_word: assert property ($fell(rst) |-> status_word == 8'ha0)
    else $error("wrong word after reset");
  // Busy one cycle later in the word shows the event met a running command
  a_crc_flag: assert property ((crc_error && !cmd_start && cls_reg inside
    {FSW_CMD_POSITION, FSW_CMD_READ_DATA, FSW_CMD_WRITE_DATA, FSW_CMD_READ_ADDRESS})
    ##1 status_word[FSW_BIT_BUSY] |-> ##1 status_word[FSW_BIT_CRC])
    else $error("crc bit not set");
  a_drq_release: assert property (($fell(read_strobe_n & write_strobe_n)
    && reg_select == FSW_ADDR_DATA) |-> ##[1:DRQ_MAX] !data_request_out)
    else $error("data request held too long");
  a_irq_release: assert property (($fell(read_strobe_n)
    && reg_select == FSW_ADDR_STATUS) |-> ##[1:IRQ_MAX] !irq_out)
    else $error("interrupt held too long");
  a_step_width: assert property ($fell(step_out)
    |-> hi_reg >= (mfm_mode ? STEP_MFM_CYC : STEP_FM_CYC))
    else $error("step pulse too short");
endmodule

bind fsw_status_word fsw_status_word_mon #(.STEP_MFM_CYC(STEP_MFM_CYC),
  .STEP_FM_CYC(STEP_FM_CYC)) u_mon (.sys_clk, .rst, .master_reset_n, .drive_ready_in,
  .reg_select, .read_strobe_n, .write_strobe_n, .cmd_start, .cmd_class, .cmd_done,
  .crc_error, .mfm_mode, .status_word, .data_request_out, .irq_out, .step_out);

// ---- fsw_host_model.sv ----
// Host processor model on the strobed register port
`timescale 1ns/1ps
module fsw_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic data_request_out,
  input wire logic serve_en,
  input wire logic serve_write,
  input wire logic [9:0] serve_delay,
  input wire logic status_rd,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [1:0] reg_select
);
  logic [9:0] cnt_reg;
  logic [3:0] hold_reg;
  // Strobes stay low 8 cycles to meet the 150 ns minimum pulse width
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      reg_select <= 2'h3;
      cnt_reg <= 10'h0;
      hold_reg <= 4'h0;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
      read_strobe_n <= read_strobe_n | (hold_reg == 4'h1);
      write_strobe_n <= write_strobe_n | (hold_reg == 4'h1);
    end else if (status_rd) begin
      reg_select <= 2'h0;
      read_strobe_n <= 1'b0;
      hold_reg <= 4'h8;
    end else if (serve_en && data_request_out) begin
      // Delay stays below 675 cycles for reads, 475 for writes
      cnt_reg <= cnt_reg + 10'h1;
      if (cnt_reg >= serve_delay) begin
        reg_select <= 2'h3;
        read_strobe_n <= serve_write;
        write_strobe_n <= !serve_write;
        hold_reg <= 4'h8;
        cnt_reg <= 10'h0;
      end
    end else begin
      cnt_reg <= 10'h0;
    end
  end
endmodule

// ---- tb_fdc_status_word_logic.sv ----
// Self-checking bench for the status-word block
`timescale 1ns/1ps
module tb_fdc_status_word_logic;
  import fsw_pkg::*;
  localparam int MFM_C = 5;
  localparam int FM_C = 10;
  logic sys_clk = 1'b0, rst = 1'b1, master_reset_n = 1'b1, drive_ready_in = 1'b0;
  logic write_protect_in = 1'b1, outer_track_in = 1'b1, index_pulse_in = 1'b1;
  logic cmd_start = 1'b0, extended_mode = 1'b0, mfm_mode = 1'b1;
  logic serve_en = 1'b0, serve_write = 1'b0;
  logic [9:0] serve_delay = 10'h0;
  logic [11:0] pv = 12'h0;
  fsw_cmd_t cmd_class = FSW_CMD_POSITION;
  logic [1:0] reg_select;
  logic read_strobe_n, write_strobe_n, data_request_out, irq_out, step_out;
  logic [7:0] status_word;
  int failures = 0;
  int checks_done = 0;
  always #10 sys_clk = ~sys_clk;
  fsw_status_word #(.STEP_MFM_CYC(MFM_C), .STEP_FM_CYC(FM_C)) u_dut (
    .sys_clk, .rst, .master_reset_n, .drive_ready_in, .write_protect_in, .outer_track_in,
    .index_pulse_in, .reg_select, .read_strobe_n, .write_strobe_n, .cmd_start, .cmd_class,
    .cmd_done(pv[8]), .force_irq(pv[9]), .extended_mode, .mfm_mode, .verify_fail(pv[0]),
    .crc_error(pv[1]), .mark_missing(pv[2]), .deleted_mark(pv[3]), .record_not_found(pv[4]),
    .lost_data(pv[5]), .data_request_set(pv[6]), .irq_set(pv[7]), .step_request(pv[10]),
    .status_word, .data_request_out, .irq_out, .step_out);
  fsw_host_model u_host (.sys_clk, .rst, .data_request_out, .serve_en, .serve_write,
    .serve_delay, .status_rd(pv[11]), .read_strobe_n, .write_strobe_n, .reg_select);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Pulse bits: 0-7 events, 8 done, 9 force, 10 step, 11 status read
  task automatic pulse(input int i);
    pv[i] <= 1'b1;
    cyc(1);
    pv[i] <= 1'b0;
  endtask
  task automatic start(input fsw_cmd_t c);
    cmd_class <= c;
    cmd_start <= 1'b1;
    cyc(1);
    cmd_start <= 1'b0;
  endtask
  // Sample at the falling edge so no edge update races the compare
  task automatic see(input int n, input logic [10:0] e);
    cyc(n);
    @(negedge sys_clk);
    chk({irq_out, data_request_out, step_out, status_word}, e);
    @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_position();
    drive_ready_in <= 1'b1;
    see(8, 11'h020);
    write_protect_in <= 1'b0;
    outer_track_in <= 1'b0;
    start(FSW_CMD_POSITION);
    see(8, 11'h065);
    pulse(0);
    pulse(1);
    see(3, 11'h07d);
    index_pulse_in <= 1'b0;
    see(8, 11'h07f);
    index_pulse_in <= 1'b1;
    cyc(8);
    pulse(8);
    see(3, 11'h07c);
    start(FSW_CMD_POSITION);
    see(3, 11'h065);
    pulse(8);
  endtask
  task automatic t_read(input logic m);
    outer_track_in <= 1'b1;
    extended_mode <= m;
    start(FSW_CMD_READ_DATA);
    for (int i = 2; i < 7; i++) pulse(i);
    see(3, m ? 11'h277 : 11'h237);
    serve_delay <= m ? 10'h12c : 10'h003;
    serve_write <= m;
    serve_en <= 1'b1;
    see(m ? 320 : 25, m ? 11'h075 : 11'h035);
    serve_en <= 1'b0;
    pulse(7);
    pulse(8);
    see(3, m ? 11'h474 : 11'h434);
    pulse(11);
    see(30, m ? 11'h074 : 11'h034);
  endtask
  task automatic t_misc();
    start(FSW_CMD_MISC);
    pulse(1);
    pulse(0);
    see(3, 11'h001);
    pulse(7);
    pulse(9);
    see(3, 11'h400);
    pulse(9);
    see(3, 11'h440);
    pulse(11);
    see(30, 11'h040);
  endtask
  // Remaining layouts: events 1 to 5 pulsed, only the layout's own bits show
  task automatic t_layout(input fsw_cmd_t c, input logic [7:0] e);
    start(c);
    for (int i = 1; i < 6; i++) pulse(i);
    see(3, {3'h0, e});
    pulse(8);
  endtask
  task automatic t_step(input logic m);
    int n;
    mfm_mode <= m;
    pulse(10);
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk);
      if (step_out !== 1'b1) break;
    end
    if (n == 40) begin
      failures++;
      conclude();
    end
    chk(11'(n), m ? 11'(MFM_C) : 11'(FM_C));
    cyc(2);
  endtask
  task automatic t_ready();
    start(FSW_CMD_READ_DATA);
    drive_ready_in <= 1'b0;
    see(8, 11'h081);
    master_reset_n <= 1'b0;
    see(8, 11'h0e0);
    master_reset_n <= 1'b1;
    drive_ready_in <= 1'b1;
    see(8, 11'h060);
  endtask
  // Reset for 10 cycles, then every scenario in turn
  initial begin
    cyc(10);
    rst <= 1'b0;
    see(0, 11'h0a0);
    t_position();
    t_read(1'b0);
    t_read(1'b1);
    t_misc();
    t_step(1'b1);
    t_step(1'b0);
    t_layout(FSW_CMD_WRITE_DATA, 8'h1d);
    t_layout(FSW_CMD_READ_ADDRESS, 8'h1d);
    t_layout(FSW_CMD_TRACK_RW, 8'h45);
    t_layout(FSW_CMD_FORMAT, 8'h4d);
    t_ready();
    conclude();
  end
endmodule
